/* logic/imu_divider.sv */
// Iterative signed divider: 32-bit dividend by 16-bit divisor, truncating
`timescale 1ns/1ps
`include "imu_consts.svh"

module imu_divider (
  input logic clk,
  input logic rst_b,
  input logic start,
  input logic [31:0] dividend,
  input logic [15:0] divisor,
  output logic done,
  output logic [31:0] quotient,
  output logic [15:0] remainder
);
  logic [31:0] q_q;
  logic [16:0] r_q;
  logic [16:0] d_q;
  logic qneg_q;
  logic rneg_q;
  logic run_q;
  logic done_q;
  logic [5:0] cnt_q;
  logic [17:0] shifted;
  logic fits;
  logic last;

  assign shifted = {r_q, q_q[31]};
  assign fits = shifted >= {1'b0, d_q};
  assign last = cnt_q == 6'(`IMU_DIV_STEPS - 1);

  // Magnitudes are loaded once; one quotient bit per clock after that
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_q <= 32'h0;
      r_q <= 17'h0;
      d_q <= 17'h0;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= 6'h0;
    end else if (start) begin
      q_q <= dividend[31] ? -dividend : dividend;
      r_q <= 17'h0;
      d_q <= divisor[15] ? -{1'b1, divisor} : {1'b0, divisor};
      qneg_q <= dividend[31] ^ divisor[15];
      rneg_q <= dividend[31];
      run_q <= 1'b1;
      cnt_q <= 6'h0;
    end else if (run_q) begin
      q_q <= {q_q[30:0], fits};
      r_q <= fits ? 17'(shifted - {1'b0, d_q}) : shifted[16:0];
      cnt_q <= cnt_q + 6'h1;
      run_q <= !last;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= run_q && last && !start;
    end
  end

  assign done = done_q;
  assign quotient = qneg_q ? -q_q : q_q;
  assign remainder = rneg_q ? 16'(-r_q) : r_q[15:0];
endmodule : imu_divider

/* logic/imu_math_unit.sv */
// Integer math unit: operations, arithmetic flags, trap, fault and math register
`timescale 1ns/1ps
`include "imu_consts.svh"

module imu_math_unit
  import imu_pkg::*;
(
  input logic MCLK,
  input logic RST_B,
  input logic [3:0] ADDR,
  input logic [15:0] WDATA,
  input logic WR,
  input logic RD,
  output logic [15:0] RDATA,
  input logic OP_VALID,
  input logic RUNG_TRUE,
  input logic [3:0] OP_CODE,
  input logic [15:0] SRC_A,
  input logic [15:0] SRC_B,
  input logic [15:0] SRC_C,
  output logic BUSY,
  output logic DEST_VALID,
  output logic [15:0] DEST_DATA,
  input logic SCAN_END,
  output logic MAJOR_FAULT,
  output logic [15:0] FAULT_CODE
);
  imu_state_t state_q;
  imu_state_t state_d;
  imu_op_t op;
  imu_op_t op_q;
  logic take;
  logic [3:0] flags_q;
  logic osel_q;
  logic trap_q;
  logic fault_q;
  logic [15:0] fault_code_q;
  logic [15:0] mreg_lo_q;
  logic [15:0] mreg_hi_q;
  logic [15:0] rdata_q;
  logic busy_q;
  logic dest_valid_q;
  logic [15:0] dest_data_q;
  logic [15:0] div_b_q;
  logic dvd_neg_q;
  logic signed [47:0] a48;
  logic signed [47:0] b48;
  logic signed [47:0] c48;
  logic signed [47:0] prod48;
  logic [16:0] usum;
  logic [19:0] bcd;
  logic div_start;
  logic div_done;
  logic [31:0] div_dvd;
  logic [31:0] div_quo;
  logic [15:0] div_rem;
  logic [16:0] rem_mag;
  logic [16:0] dvs_mag;
  logic round_up;
  logic signed [47:0] q48;
  logic signed [47:0] qr48;
  logic root_start;
  logic root_done;
  logic [7:0] root_val;
  logic [16:0] src_a_mag;
  logic fin_v;
  logic [16:0] fin_word;
  logic fin_carry;
  logic fin_err;
  logic fin_mwr;
  logic [15:0] fin_mlo;
  logic [15:0] fin_mhi;

  // Fits a wide signed result into a word: {overflow, destination value}
  function automatic logic [16:0] fit16(input logic signed [47:0] v, input logic trunc);
    if (v > `IMU_POS_LIM) begin
      return {1'b1, trunc ? v[15:0] : `IMU_POS_MAX};
    end else if (v < `IMU_NEG_LIM) begin
      return {1'b1, trunc ? v[15:0] : `IMU_NEG_MAX};
    end
    return {1'b0, v[15:0]};
  endfunction : fit16

  function automatic logic [16:0] mag16(input logic [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return v[15] ? -e : e;
  endfunction : mag16

  function automatic logic [19:0] bin2bcd(input logic [15:0] v);
    logic [35:0] s;
    s = {20'h0, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 5; d++) begin
        if (s[16 + 4 * d +: 4] >= 4'h5) begin
          s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[35:16];
  endfunction : bin2bcd

  function automatic logic [31:0] bcd2bin(input logic [19:0] d);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 4; i >= 0; i--) begin
      v = v * 32'd10 + {28'h0, d[4 * i +: 4]};
    end
    return v;
  endfunction : bcd2bin

  assign op = imu_op_t'(OP_CODE);
  assign take = OP_VALID && RUNG_TRUE && state_q == ST_IDLE;
  assign a48 = 48'($signed(SRC_A));
  assign b48 = 48'($signed(SRC_B));
  assign c48 = 48'($signed(SRC_C));
  assign prod48 = a48 * b48;
  assign usum = {1'b0, SRC_A} + {1'b0, SRC_B};
  assign bcd = bin2bcd(SRC_A);

  assign div_start = take && (op == OP_QUOT || op == OP_WIDE_QUOT) && SRC_B != 16'h0;
  assign div_dvd = (op == OP_WIDE_QUOT) ? {mreg_hi_q, mreg_lo_q} : 32'(a48);
  assign root_start = take && op == OP_ROOT;
  assign rem_mag = mag16(div_rem);
  assign dvs_mag = mag16(div_b_q);
  // Root works on the magnitude; a full-scale negative source still fits 16 bits
  assign src_a_mag = mag16(SRC_A);
  assign round_up = {rem_mag, 1'b0} >= {1'b0, dvs_mag};
  assign q48 = 48'($signed(div_quo));
  assign qr48 = q48 + (round_up ? (dvd_neg_q ^ div_b_q[15] ? -48'sd1 : 48'sd1) : 48'sd0);

  imu_divider i_imu_divider (
    .clk(MCLK),
    .rst_b(RST_B),
    .start(div_start),
    .dividend(div_dvd),
    .divisor(SRC_B),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  imu_root i_imu_root (
    .clk(MCLK),
    .rst_b(RST_B),
    .start(root_start),
    .radicand(src_a_mag[15:0]),
    .done(root_done),
    .root(root_val)
  );

  // Result of the operation that completes in this cycle
  always_comb begin
    fin_v = 1'b0;
    fin_word = 17'h0;
    fin_carry = 1'b0;
    fin_mwr = 1'b0;
    fin_mlo = mreg_lo_q;
    fin_mhi = mreg_hi_q;
    if (take) begin
      fin_v = 1'b1;
      unique case (op)
        OP_SUM: begin
          fin_word = fit16(a48 + b48, osel_q);
          fin_carry = usum[16];
        end
        OP_DIFF: begin
          fin_word = fit16(a48 - b48, osel_q);
          fin_carry = SRC_A < SRC_B;
        end
        OP_PRODUCT: begin
          fin_word = fit16(prod48, osel_q);
          fin_mwr = prod48 > `IMU_POS_LIM || prod48 < `IMU_PROD_NEG_LIM;
          fin_mlo = prod48[15:0];
          fin_mhi = prod48[31:16];
        end
        OP_QUOT, OP_WIDE_QUOT: begin
          // Divide by zero completes at once as an overflow
          fin_v = SRC_B == 16'h0;
          fin_word = fit16(div_dvd[31] ? -48'sh1_0000_0000 : 48'sh1_0000_0000, 1'b0);
        end
        OP_ZERO_WORD: begin
          fin_word = 17'h0;
        end
        OP_ROOT: begin
          fin_v = 1'b0;
        end
        OP_RATE_OFFSET: begin
          fin_word = fit16(prod48 + c48, osel_q);
        end
        OP_BCD_TO_BINARY: begin
          fin_word = fit16(48'(bcd2bin({mreg_hi_q[3:0], mreg_lo_q})), osel_q);
        end
        OP_BINARY_TO_BCD: begin
          fin_word = {1'b0, bcd[15:0]};
          fin_mwr = 1'b1;
          fin_mlo = bcd[15:0];
          fin_mhi = {12'h0, bcd[19:16]};
        end
        default: begin
          fin_v = 1'b0;
        end
      endcase
    end else if (state_q == ST_DIVIDE && div_done) begin
      fin_v = 1'b1;
      fin_word = fit16(qr48, op_q == OP_QUOT && osel_q);
      fin_mwr = op_q == OP_QUOT || !fin_word[16];
      fin_mlo = div_rem;
      fin_mhi = div_quo[15:0];
    end else if (state_q == ST_ROOT && root_done) begin
      fin_v = 1'b1;
      fin_word = {9'h0, root_val};
    end
  end

  assign fin_err = fin_v && fin_word[16];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (div_start) begin
          state_d = ST_DIVIDE;
        end else if (root_start) begin
          state_d = ST_ROOT;
        end
      end
      ST_DIVIDE: begin
        if (div_done) begin
          state_d = ST_IDLE;
        end
      end
      ST_ROOT: begin
        if (root_done) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      op_q <= OP_SUM;
      div_b_q <= 16'h0;
      dvd_neg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= state_d != ST_IDLE;
      if (take) begin
        op_q <= op;
        div_b_q <= SRC_B;
        dvd_neg_q <= div_dvd[31];
      end
    end
  end

  // Destination holds its value when nothing completes
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      dest_valid_q <= 1'b0;
      dest_data_q <= 16'h0;
    end else begin
      dest_valid_q <= fin_v;
      if (fin_v) begin
        dest_data_q <= fin_word[15:0];
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      flags_q <= 4'h0;
    end else if (fin_v) begin
      flags_q[`IMU_BIT_CARRY] <= fin_carry;
      flags_q[`IMU_BIT_OVF] <= fin_word[16];
      flags_q[`IMU_BIT_ZERO] <= fin_word[15:0] == 16'h0;
      flags_q[`IMU_BIT_SIGN] <= fin_word[15];
    end else if (WR && ADDR == `IMU_OFF_FLAGS) begin
      flags_q <= WDATA[3:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      osel_q <= 1'b0;
    end else if (WR && ADDR == `IMU_OFF_CTRL) begin
      osel_q <= WDATA[`IMU_BIT_OSEL];
    end
  end

  // Hardware setting of the trap wins over a software clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      trap_q <= 1'b0;
    end else if (fin_err) begin
      trap_q <= 1'b1;
    end else if (WR && ADDR == `IMU_OFF_MINOR) begin
      trap_q <= WDATA[`IMU_BIT_TRAP];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      fault_q <= 1'b0;
      fault_code_q <= 16'h0;
    end else if (SCAN_END && trap_q) begin
      fault_q <= 1'b1;
      fault_code_q <= `IMU_FAULT_CODE;
    end else if (WR && ADDR == `IMU_OFF_FAULT) begin
      fault_q <= 1'b0;
      fault_code_q <= 16'h0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      mreg_lo_q <= 16'h0;
      mreg_hi_q <= 16'h0;
    end else if (fin_v && fin_mwr) begin
      mreg_lo_q <= fin_mlo;
      mreg_hi_q <= fin_mhi;
    end else if (WR) begin
      if (ADDR == `IMU_OFF_MATH_LO) begin
        mreg_lo_q <= WDATA;
      end
      if (ADDR == `IMU_OFF_MATH_HI) begin
        mreg_hi_q <= WDATA;
      end
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      rdata_q <= 16'h0;
    end else if (RD) begin
      case (ADDR)
        `IMU_OFF_FLAGS: rdata_q <= {12'h0, flags_q};
        `IMU_OFF_CTRL: rdata_q <= 16'(osel_q) << `IMU_BIT_OSEL;
        `IMU_OFF_MINOR: rdata_q <= {15'h0, trap_q};
        `IMU_OFF_FAULT: rdata_q <= fault_code_q;
        `IMU_OFF_MATH_LO: rdata_q <= mreg_lo_q;
        `IMU_OFF_MATH_HI: rdata_q <= mreg_hi_q;
        default: rdata_q <= 16'h0;
      endcase
    end else begin
      rdata_q <= 16'h0;
    end
  end

  assign RDATA = rdata_q;
  assign BUSY = busy_q;
  assign DEST_VALID = dest_valid_q;
  assign DEST_DATA = dest_data_q;
  assign MAJOR_FAULT = fault_q;
  assign FAULT_CODE = fault_code_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  sequence s_div_launch;
    take && op == OP_QUOT && SRC_B != 16'h0;
  endsequence
  sequence s_root_launch;
    take && op == OP_ROOT;
  endsequence

  a_rung_false_idle: assert property (
    OP_VALID && !RUNG_TRUE && !BUSY && state_q == ST_IDLE |=> !DEST_VALID)
    else $error("operation ran with rung condition false");
  a_sum_truncated: assert property (
    take && op == OP_SUM && osel_q
    |=> DEST_VALID && DEST_DATA == 16'($past(SRC_A) + $past(SRC_B)))
    else $error("sum destination wrong");
  a_diff_saturate: assert property (
    take && op == OP_DIFF && !osel_q && (a48 - b48) > `IMU_POS_LIM
    |=> DEST_DATA == `IMU_POS_MAX && flags_q[`IMU_BIT_OVF] && trap_q)
    else $error("difference did not saturate");
  a_zero_word_flags: assert property (
    take && op == OP_ZERO_WORD |=> DEST_DATA == 16'h0 && flags_q == 4'h4)
    else $error("zero-word result or flags wrong");
  a_sign_zero_flags: assert property (
    DEST_VALID |-> flags_q[`IMU_BIT_SIGN] == DEST_DATA[15]
    && flags_q[`IMU_BIT_ZERO] == (DEST_DATA == 16'h0))
    else $error("sign or zero flag disagrees with destination");
  a_carry_add: assert property (
    take && op == OP_SUM && SRC_A == 16'hffff && SRC_B == 16'h0001
    |=> flags_q[`IMU_BIT_CARRY] && flags_q[`IMU_BIT_ZERO])
    else $error("carry not set on add wrap");
  a_overflow_traps: assert property (
    DEST_VALID && flags_q[`IMU_BIT_OVF] |-> trap_q)
    else $error("overflow without trap bit");
  a_fault_raised: assert property (
    SCAN_END && trap_q |=> MAJOR_FAULT && FAULT_CODE == `IMU_FAULT_CODE)
    else $error("trap at scan end did not raise fault");
  a_product_mreg: assert property (
    take && op == OP_PRODUCT && prod48 > `IMU_POS_LIM
    |=> {mreg_hi_q, mreg_lo_q} == 32'($past(prod48)))
    else $error("wide product not in math register");
  a_div_latency: assert property (
    s_div_launch |-> ##34 (DEST_VALID && $past(state_q) == ST_DIVIDE))
    else $error("quotient not delivered in time");
  a_root_latency: assert property (
    s_root_launch |-> ##10 DEST_VALID && DEST_DATA[15:8] == 8'h0)
    else $error("root not delivered in time");
  a_bcd_digits: assert property (
    take && op == OP_BINARY_TO_BCD && SRC_A == 16'h3039
    |=> mreg_lo_q == 16'h2345 && mreg_hi_q == 16'h0001)
    else $error("BCD digits misplaced");
endmodule : imu_math_unit

/* logic/imu_root.sv */
// Iterative integer square root of a 16-bit unsigned value
`timescale 1ns/1ps
`include "imu_consts.svh"

module imu_root (
  input logic clk,
  input logic rst_b,
  input logic start,
  input logic [15:0] radicand,
  output logic done,
  output logic [7:0] root
);
  logic [15:0] x_q;
  logic [7:0] res_q;
  logic [2:0] cnt_q;
  logic run_q;
  logic done_q;
  logic [7:0] trial;
  logic [15:0] square;
  logic last;

  assign trial = res_q | (8'h80 >> cnt_q);
  assign square = 16'({8'h0, trial} * {8'h0, trial});
  assign last = cnt_q == 3'(`IMU_ROOT_STEPS - 1);

  // Keeps each trial bit whose square still fits under the radicand
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      x_q <= 16'h0;
      res_q <= 8'h0;
      cnt_q <= 3'h0;
      run_q <= 1'b0;
    end else if (start) begin
      x_q <= radicand;
      res_q <= 8'h0;
      cnt_q <= 3'h0;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (square <= x_q) begin
        res_q <= trial;
      end
      cnt_q <= cnt_q + 3'h1;
      run_q <= !last;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= run_q && last && !start;
    end
  end

  assign done = done_q;
  assign root = res_q;
endmodule : imu_root

/* pkg/imu_consts.svh */
// Register offsets, field positions, limits and step counts of the math unit
`ifndef IMU_CONSTS_SVH
`define IMU_CONSTS_SVH
`define IMU_OFF_FLAGS 4'h0
`define IMU_OFF_CTRL 4'h2
`define IMU_OFF_MINOR 4'h5
`define IMU_OFF_FAULT 4'h6
`define IMU_OFF_MATH_LO 4'hd
`define IMU_OFF_MATH_HI 4'he
`define IMU_BIT_CARRY 0
`define IMU_BIT_OVF 1
`define IMU_BIT_ZERO 2
`define IMU_BIT_SIGN 3
`define IMU_BIT_OSEL 14
`define IMU_BIT_TRAP 0
`define IMU_POS_MAX 16'h7fff
`define IMU_NEG_MAX 16'h8000
`define IMU_POS_LIM 48'sh0000_0000_7fff
`define IMU_NEG_LIM 48'shffff_ffff_8000
`define IMU_PROD_NEG_LIM 48'shffff_ffff_8001
`define IMU_FAULT_CODE 16'h0020
`define IMU_DIV_STEPS 32
`define IMU_ROOT_STEPS 8
`endif

/* pkg/imu_pkg.sv */
// Operation codes and sequencer states of the math unit
package imu_pkg;
  typedef enum logic [3:0] {
    OP_SUM,
    OP_DIFF,
    OP_PRODUCT,
    OP_QUOT,
    OP_WIDE_QUOT,
    OP_ZERO_WORD,
    OP_ROOT,
    OP_RATE_OFFSET,
    OP_BCD_TO_BINARY,
    OP_BINARY_TO_BCD
  } imu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DIVIDE,
    ST_ROOT
  } imu_state_t;
endpackage : imu_pkg

/* sim/tb_integer_math_unit_with_flags.sv */
// Self-checking bench for the integer math unit
`timescale 1ns/1ps
`include "imu_consts.svh"

module tb_integer_math_unit_with_flags import imu_pkg::*;;
  logic MCLK, RST_B, WR, RD, OP_VALID, RUNG_TRUE, SCAN_END;
  logic BUSY, DEST_VALID, MAJOR_FAULT;
  logic [3:0] ADDR, OP_CODE;
  logic [15:0] WDATA, RDATA, SRC_A, SRC_B, SRC_C, DEST_DATA, FAULT_CODE;
  int err_total;
  int compares;

  imu_math_unit i_imu_math_unit (
    .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .OP_VALID(OP_VALID), .RUNG_TRUE(RUNG_TRUE), .OP_CODE(OP_CODE),
    .SRC_A(SRC_A), .SRC_B(SRC_B), .SRC_C(SRC_C), .BUSY(BUSY), .DEST_VALID(DEST_VALID),
    .DEST_DATA(DEST_DATA), .SCAN_END(SCAN_END), .MAJOR_FAULT(MAJOR_FAULT),
    .FAULT_CODE(FAULT_CODE)
  );

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
    compares++;
    if (act !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    chk(what, exp, RDATA);
  endtask : rdc

  // Issues one request; a refused one must give no result pulse within five cycles
  task automatic op(input logic [3:0] code, input logic [15:0] a, input logic [15:0] b,
                    input logic [15:0] c, input logic rung, input logic [15:0] exp_d,
                    input logic [3:0] exp_f);
    int n;
    logic seen;
    logic go;
    logic long_op;
    go = rung && (code < 4'ha);
    seen = 1'b0;
    long_op = go && (((code == OP_QUOT || code == OP_WIDE_QUOT) && b != 16'h0) || code == OP_ROOT);
    @(posedge MCLK);
    OP_VALID <= 1'b1;
    RUNG_TRUE <= rung;
    OP_CODE <= code;
    SRC_A <= a;
    SRC_B <= b;
    SRC_C <= c;
    @(posedge MCLK);
    OP_VALID <= 1'b0;
    for (n = 0; n < (go ? 60 : 5) && !seen; n++) begin
      @(negedge MCLK);
      seen = (DEST_VALID === 1'b1);
      if (n == 0) begin
        chk("busy", {15'h0000, long_op}, {15'h0000, BUSY});
      end
    end
    chk("dest_valid", {15'h0000, go}, {15'h0000, seen});
    if (go && !seen) begin
      give_verdict();
    end
    chk("dest_data", exp_d, DEST_DATA);
    rdc(`IMU_OFF_FLAGS, {12'h000, exp_f}, "flags");
  endtask : op

  task automatic scan(input logic exp_fault);
    @(posedge MCLK);
    SCAN_END <= 1'b1;
    @(posedge MCLK);
    SCAN_END <= 1'b0;
    @(negedge MCLK);
    chk("major_fault", {15'h0000, exp_fault}, {15'h0000, MAJOR_FAULT});
    chk("fault_code", exp_fault ? `IMU_FAULT_CODE : 16'h0000, FAULT_CODE);
  endtask : scan

  initial begin
    err_total = 0;
    compares = 0;
    RST_B = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 16'h0000;
    OP_VALID = 1'b0;
    RUNG_TRUE = 1'b0;
    OP_CODE = 4'h0;
    SRC_A = 16'h0000;
    SRC_B = 16'h0000;
    SRC_C = 16'h0000;
    SCAN_END = 1'b0;
    repeat (10) @(posedge MCLK);
    RST_B <= 1'b1;
    rdc(`IMU_OFF_FLAGS, 16'h0000, "flags_rst");
    rdc(`IMU_OFF_MINOR, 16'h0000, "trap_rst");
    rdc(`IMU_OFF_FAULT, 16'h0000, "fault_rst");
    wr(`IMU_OFF_MATH_LO, 16'h1234);
    rdc(`IMU_OFF_MATH_LO, 16'h1234, "math_lo_rw");
    wr(4'h9, 16'habcd);
    rdc(4'h9, 16'h0000, "unmapped");
    op(OP_SUM, 16'h0001, 16'h0002, 16'h0000, 1'b1, 16'h0003, 4'h0);
    op(OP_SUM, 16'hffff, 16'h0001, 16'h0000, 1'b1, 16'h0000, 4'h5);
    op(OP_DIFF, 16'h0001, 16'h0002, 16'h0000, 1'b1, 16'hffff, 4'h9);
    op(OP_SUM, 16'h7fff, 16'h0001, 16'h0000, 1'b1, 16'h7fff, 4'h2);
    op(OP_DIFF, 16'h7fff, 16'hffff, 16'h0000, 1'b1, 16'h7fff, 4'h3);
    op(OP_DIFF, 16'h8000, 16'h0001, 16'h0000, 1'b1, 16'h8000, 4'ha);
    rdc(`IMU_OFF_MINOR, 16'h0001, "trap_ovf");
    scan(1'b1);
    wr(`IMU_OFF_FAULT, 16'h0000);
    @(negedge MCLK);
    chk("fault_clear", 16'h0000, {15'h0000, MAJOR_FAULT});
    // Program unlatches the trap before the scan ends
    wr(`IMU_OFF_MINOR, 16'h0000);
    scan(1'b0);
    wr(`IMU_OFF_CTRL, 16'h4000);
    op(OP_SUM, 16'h7fff, 16'h0001, 16'h0000, 1'b1, 16'h8000, 4'ha);
    wr(`IMU_OFF_CTRL, 16'h0000);
    op(OP_PRODUCT, 16'h012c, 16'h00c8, 16'h0000, 1'b1, 16'h7fff, 4'h2);
    rdc(`IMU_OFF_MATH_LO, 16'hea60, "prod_lo");
    rdc(`IMU_OFF_MATH_HI, 16'h0000, "prod_hi");
    op(OP_QUOT, 16'hfff9, 16'h0002, 16'h0000, 1'b1, 16'hfffc, 4'h8);
    rdc(`IMU_OFF_MATH_HI, 16'hfffd, "quot_hi");
    rdc(`IMU_OFF_MATH_LO, 16'hffff, "quot_lo");
    wr(`IMU_OFF_MINOR, 16'h0000);
    op(OP_QUOT, 16'h0005, 16'h0000, 16'h0000, 1'b1, 16'h7fff, 4'h2);
    rdc(`IMU_OFF_MINOR, 16'h0001, "trap_div0");
    wr(`IMU_OFF_MATH_HI, 16'h0001);
    wr(`IMU_OFF_MATH_LO, 16'h0000);
    op(OP_WIDE_QUOT, 16'h0004, 16'h0004, 16'h0000, 1'b1, 16'h4000, 4'h0);
    op(OP_ZERO_WORD, 16'h1234, 16'h1234, 16'h0000, 1'b1, 16'h0000, 4'h4);
    op(OP_ROOT, 16'h0011, 16'h0011, 16'h0000, 1'b1, 16'h0004, 4'h0);
    op(OP_RATE_OFFSET, 16'h0003, 16'h0004, 16'h0005, 1'b1, 16'h0011, 4'h0);
    op(OP_BINARY_TO_BCD, 16'h3039, 16'h0000, 16'h0000, 1'b1, 16'h2345, 4'h0);
    rdc(`IMU_OFF_MATH_LO, 16'h2345, "bcd_lo");
    rdc(`IMU_OFF_MATH_HI, 16'h0001, "bcd_hi");
    op(OP_SUM, 16'h0002, 16'h0003, 16'h0000, 1'b0, 16'h2345, 4'h0);
    op(4'hf, 16'h0002, 16'h0003, 16'h0000, 1'b1, 16'h2345, 4'h0);
    give_verdict();
  end
endmodule : tb_integer_math_unit_with_flags
